// ---- inc/p2fc_params.svh ----
`ifndef P2FC_PARAMS_SVH
`define P2FC_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define P2FC_ADDR_W 12
`define P2FC_REG_OFFSET 12'h1a4
`define P2FC_DATA_W 32

// ----------------------------------------
// Field positions of the pause config word
// ----------------------------------------
`define P2FC_BIT_BP 6
`define P2FC_BIT_DUP 5
`define P2FC_BIT_RXNOW 4
`define P2FC_BIT_TXNOW 3
`define P2FC_BIT_RXEN 2
`define P2FC_BIT_TXEN 1
`define P2FC_BIT_MAN 0
`define P2FC_RSV_LSB 7
`define P2FC_RSV_W 25

// ----------------------------------------
// Constant words
// ----------------------------------------
`define P2FC_ZERO_WORD 32'h0000_0000
`define P2FC_RSV_ZERO 25'h000_0000

`endif

// ---- inc/p2fc_pkg.sv ----
package p2fc_pkg;

  // ----------------------------------------
  // Software-written controls
  // ----------------------------------------
  typedef struct packed {
    logic bpEn;   // p2_backpressure_en
    logic rxEn;   // p2_rx_pause_en
    logic txEn;   // p2_tx_pause_en
    logic manSel; // p2_pause_manual_sel
  } p2fc_cfg_t;

  // ----------------------------------------
  // Flow control in force
  // ----------------------------------------
  typedef struct packed {
    logic halfDup; // p2_duplex_now, 1 = half
    logic rxNow;   // p2_rx_pause_now
    logic txNow;   // p2_tx_pause_now
  } p2fc_stat_t;

  // Picks manual or negotiated pause; none in half duplex
  function automatic p2fc_stat_t p2fc_resolve_fn(
    input p2fc_cfg_t cfg,
    input logic anOn,
    input logic half,
    input logic anRx,
    input logic anTx
  );
    p2fc_stat_t s;
    s.halfDup = half;
    s.rxNow = 1'b0;
    s.txNow = 1'b0;
    if (!half) begin
      if (cfg.manSel || !anOn) begin
        s.rxNow = cfg.rxEn;
        s.txNow = cfg.txEn;
      end else begin
        s.rxNow = anRx;
        s.txNow = anTx;
      end
    end
    return s;
  endfunction

endpackage

// ---- inc/p2fc_bus_if.sv ----
`timescale 1ns/1ps
// Link between the bus slave and the register core
interface p2fc_bus_if;
  logic wrStb;         // One-cycle write of the config word
  logic [31:0] wrData; // Write data
  logic [31:0] rdWord; // Live readback word
  modport slave(output wrStb, output wrData, input rdWord);
  modport core(input wrStb, input wrData, output rdWord);
endinterface

// ---- hw/p2fc_apb_slave.sv ----
`timescale 1ns/1ps
`include "p2fc_params.svh"
module p2fc_apb_slave
  import p2fc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`P2FC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  p2fc_bus_if.slave bus
);

  // ----------------------------------------
  // Decode and answer
  // ----------------------------------------
  logic hit;            // Address names the register
  logic setup;          // Setup phase of a transfer
  logic pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;

  assign hit = (paddr == `P2FC_REG_OFFSET);
  assign setup = psel && !penable;
  assign bus.wrStb = psel && penable && pready_q && pwrite && hit && clkEn;
  assign bus.wrData = pwdata;
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Next answer, built during the setup phase
  always_comb begin
    pready_d = setup;
    prdata_d = `P2FC_ZERO_WORD;
    pslverr_d = setup && !hit;
    if (setup && hit && !pwrite) begin
      prdata_d = bus.rdWord;
    end
  end

  // Answer flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      prdata_q <= `P2FC_ZERO_WORD;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_ready_one_wait: assert property (
    (setup && clkEn) |=> pready)
    else $error("pready not raised after setup");

  chk_unmapped_error: assert property (
    (setup && !hit && clkEn) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  chk_reserved_zero: assert property (
    prdata[31:`P2FC_RSV_LSB] == `P2FC_RSV_ZERO)
    else $error("reserved bits read nonzero");

endmodule

// ---- hw/p2fc_resolve.sv ----
`timescale 1ns/1ps
`include "p2fc_params.svh"
module p2fc_resolve
  import p2fc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire p2fc_cfg_t cfg,
  input wire p2fc_cfg_t strapCfg,
  input wire logic anEnable,
  input wire logic linkHalf,
  input wire logic anRxPause,
  input wire logic anTxPause,
  output p2fc_stat_t stat
);

  // ----------------------------------------
  // Flow control in force
  // ----------------------------------------
  p2fc_stat_t stat_q, stat_d;
  logic manualMode; // Manual enables govern

  assign manualMode = cfg.manSel || !anEnable;
  assign stat = stat_q;

  // Reset value comes from straps plus link state
  always_comb begin
    if (sys_rst) begin
      stat_d = p2fc_resolve_fn(strapCfg, anEnable, linkHalf, anRxPause, anTxPause);
    end else begin
      stat_d = p2fc_resolve_fn(cfg, anEnable, linkHalf, anRxPause, anTxPause);
    end
  end

  // Status flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clkEn) begin
      stat_q <= stat_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_half_no_pause: assert property (
    stat_q.halfDup |-> !stat_q.rxNow && !stat_q.txNow)
    else $error("pause active in half duplex");

  chk_manual_follow: assert property (
    (clkEn && manualMode && !linkHalf) |=>
      stat_q.rxNow == $past(cfg.rxEn) && stat_q.txNow == $past(cfg.txEn))
    else $error("manual pause not in force");

  chk_auto_follow: assert property (
    (clkEn && !manualMode && !linkHalf) |=>
      stat_q.rxNow == $past(anRxPause) && stat_q.txNow == $past(anTxPause))
    else $error("negotiated pause not in force");

  chk_duplex_follow: assert property (
    clkEn |=> stat_q.halfDup == $past(linkHalf))
    else $error("duplex status stale");

endmodule

// ---- hw/p2fc_top.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "p2fc_params.svh"

// Summary of operation
// - Register at 1A4h, bits 31:7 reserved
// - Bit 6 enables half-duplex backpressure
// - Bit 5 reads duplex in use, 1=half
// - Bit 4 reads receive pause in force
// - Bit 3 reads transmit pause in force
// - Status shows manual or negotiated result
// - Bit 2 enables pause detection, manual mode
// - Bit 1 enables pause generation, manual mode
// - Bit 0 low with autoneg: negotiated wins
// - Manual select applies enables in full duplex
// - Writes never touch PHY advertisement
// - Reset loads control bits from straps
// - Status defaults derive from several straps
// - Loader strap rewrite updates the register
module p2fc_top
  import p2fc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`P2FC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic p2_backpressure_strap,
  input wire logic p2_pause_enable_strap,
  input wire logic p2_manual_select_strap,
  input wire logic strapReload,
  input wire logic anEnable,
  input wire logic linkHalf,
  input wire logic anRxPause,
  input wire logic anTxPause,
  output logic p2_backpressure_en,
  output logic p2_duplex_now,
  output logic p2_rx_pause_now,
  output logic p2_tx_pause_now
);

  // ----------------------------------------
  // Internal wiring
  // ----------------------------------------
  p2fc_bus_if bus ();   // Slave to core link
  p2fc_cfg_t cfg_q;     // Software controls
  p2fc_cfg_t cfg_d;     // Next controls
  p2fc_cfg_t strapCfg;  // Controls as the straps give them
  p2fc_stat_t stat;     // Flow control in force
  logic [31:0] rdWord;  // Assembled readback word

  // ----------------------------------------
  // Strap view of the controls
  // ----------------------------------------
  // One pause strap seeds both pause enables
  always_comb begin
    strapCfg.bpEn = p2_backpressure_strap;
    strapCfg.rxEn = p2_pause_enable_strap;
    strapCfg.txEn = p2_pause_enable_strap;
    strapCfg.manSel = p2_manual_select_strap;
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  p2fc_apb_slave u_slave (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .bus(bus.slave)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Next control value; loader rewrite beats a bus write
  always_comb begin
    cfg_d = cfg_q;
    if (strapReload) begin
      // Loader rewrote the straps, take them
      cfg_d = strapCfg;
    end else if (bus.wrStb) begin
      // Only the four writable bits are kept
      cfg_d.bpEn = bus.wrData[`P2FC_BIT_BP];
      cfg_d.rxEn = bus.wrData[`P2FC_BIT_RXEN];
      cfg_d.txEn = bus.wrData[`P2FC_BIT_TXEN];
      cfg_d.manSel = bus.wrData[`P2FC_BIT_MAN];
    end
  end

  // Control flops; reset captures the straps
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q <= strapCfg;
    end else if (clkEn) begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------
  // Flow control resolution
  // ----------------------------------------
  p2fc_resolve u_resolve (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .cfg(cfg_q),
    .strapCfg(strapCfg),
    .anEnable(anEnable),
    .linkHalf(linkHalf),
    .anRxPause(anRxPause),
    .anTxPause(anTxPause),
    .stat(stat)
  );

  // ----------------------------------------
  // Readback word
  // ----------------------------------------
  // Status fields are live, reserved field stays zero
  always_comb begin
    rdWord = `P2FC_ZERO_WORD;
    rdWord[`P2FC_BIT_BP] = cfg_q.bpEn;
    rdWord[`P2FC_BIT_DUP] = stat.halfDup;
    rdWord[`P2FC_BIT_RXNOW] = stat.rxNow;
    rdWord[`P2FC_BIT_TXNOW] = stat.txNow;
    rdWord[`P2FC_BIT_RXEN] = cfg_q.rxEn;
    rdWord[`P2FC_BIT_TXEN] = cfg_q.txEn;
    rdWord[`P2FC_BIT_MAN] = cfg_q.manSel;
  end
  assign bus.rdWord = rdWord;

  // ----------------------------------------
  // Outputs to the port MAC
  // ----------------------------------------
  // All straight from flops; no path to PHY advertisement
  assign p2_backpressure_en = cfg_q.bpEn;
  assign p2_duplex_now = stat.halfDup;
  assign p2_rx_pause_now = stat.rxNow;
  assign p2_tx_pause_now = stat.txNow;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_reset_straps: assert property (
    ($past(sys_rst) && !sys_rst) |-> cfg_q == $past(strapCfg))
    else $error("reset did not load straps");

  chk_write_fields: assert property (
    (bus.wrStb && !strapReload && clkEn) |=>
      cfg_q.bpEn == $past(pwdata[`P2FC_BIT_BP]) &&
      cfg_q.rxEn == $past(pwdata[`P2FC_BIT_RXEN]) &&
      cfg_q.txEn == $past(pwdata[`P2FC_BIT_TXEN]) &&
      cfg_q.manSel == $past(pwdata[`P2FC_BIT_MAN]))
    else $error("write not stored");

  chk_reload_wins: assert property (
    (strapReload && clkEn) |=> cfg_q == $past(strapCfg))
    else $error("strap reload not taken");

  chk_frozen_hold: assert property (
    !clkEn |=> $stable(cfg_q))
    else $error("controls moved while frozen");

  chk_read_word: assert property (
    (psel && !penable && !pwrite && paddr == `P2FC_REG_OFFSET && clkEn) |=>
      prdata[`P2FC_BIT_RXNOW] == $past(stat.rxNow) &&
      prdata[`P2FC_BIT_TXNOW] == $past(stat.txNow) &&
      prdata[`P2FC_BIT_DUP] == $past(stat.halfDup))
    else $error("readback status wrong");

  chk_read_ctrl: assert property (
    (psel && !penable && !pwrite && paddr == `P2FC_REG_OFFSET && clkEn) |=>
      prdata[`P2FC_BIT_TXEN] == $past(cfg_q.txEn) &&
      prdata[`P2FC_BIT_MAN] == $past(cfg_q.manSel) &&
      prdata[`P2FC_BIT_BP] == $past(cfg_q.bpEn))
    else $error("readback controls wrong");

  chk_bp_output: assert property (
    (bus.wrStb && !strapReload && clkEn) |=>
      p2_backpressure_en == $past(pwdata[`P2FC_BIT_BP]))
    else $error("backpressure output stale");

  // ----------------------------------------
  // Decode shared by the later checks
  // ----------------------------------------
  logic regRead;   // Read setup aimed at the register
  logic missWrite; // Write access phase aimed elsewhere

  assign regRead = psel && !penable && !pwrite && paddr == `P2FC_REG_OFFSET && clkEn;
  assign missWrite = psel && penable && pready && pwrite && paddr != `P2FC_REG_OFFSET;

  // Controls move only on a write, a reload or a reset
  chk_idle_controls: assert property (
    (!bus.wrStb && !strapReload && clkEn) |=>
      $stable(cfg_q))
    else $error("controls moved without a write");

  // A write to another address leaves the controls alone
  chk_miss_ignored: assert property (
    (missWrite && !strapReload) |=>
      $stable(cfg_q))
    else $error("unmapped write changed controls");

  // Receive enable reads back as stored
  chk_read_rx_en: assert property (
    regRead |=>
      prdata[`P2FC_BIT_RXEN] == $past(cfg_q.rxEn))
    else $error("receive enable readback wrong");

  // Backpressure output and readback agree
  chk_bp_readback: assert property (
    regRead |=>
      prdata[`P2FC_BIT_BP] == $past(p2_backpressure_en))
    else $error("backpressure readback differs");

  // Status outputs agree with the readback word
  chk_status_readback: assert property (
    regRead |=>
      prdata[`P2FC_BIT_DUP] == $past(p2_duplex_now) &&
      prdata[`P2FC_BIT_RXNOW] == $past(p2_rx_pause_now) &&
      prdata[`P2FC_BIT_TXNOW] == $past(p2_tx_pause_now))
    else $error("status readback differs from outputs");

  // No pause on the outputs in half duplex
  chk_half_outputs: assert property (
    p2_duplex_now |->
      !p2_rx_pause_now && !p2_tx_pause_now)
    else $error("pause output active in half duplex");

  // Manual select drives the outputs in full duplex
  chk_manual_outputs: assert property (
    (clkEn && cfg_q.manSel && !linkHalf) |=>
      p2_rx_pause_now == $past(cfg_q.rxEn) &&
      p2_tx_pause_now == $past(cfg_q.txEn))
    else $error("manual pause not on outputs");

  // Autoneg off also selects the manual enables
  chk_noauto_outputs: assert property (
    (clkEn && !anEnable && !linkHalf) |=>
      p2_rx_pause_now == $past(cfg_q.rxEn) &&
      p2_tx_pause_now == $past(cfg_q.txEn))
    else $error("manual pause ignored without autoneg");

  // Negotiated result wins with select low and autoneg on
  chk_auto_outputs: assert property (
    (clkEn && !cfg_q.manSel && anEnable && !linkHalf) |=>
      p2_rx_pause_now == $past(anRxPause) &&
      p2_tx_pause_now == $past(anTxPause))
    else $error("negotiated pause not on outputs");

  // Duplex output follows the link one edge later
  chk_duplex_output: assert property (
    clkEn |=>
      p2_duplex_now == $past(linkHalf))
    else $error("duplex output stale");

  // Reset leaves backpressure at its strap
  chk_reset_bp: assert property (
    ($past(sys_rst) && !sys_rst) |->
      p2_backpressure_en == $past(p2_backpressure_strap))
    else $error("backpressure strap not loaded");

  // One pause strap seeds both pause enables
  chk_reset_pair: assert property (
    ($past(sys_rst) && !sys_rst) |->
      cfg_q.rxEn == cfg_q.txEn)
    else $error("pause enables differ after reset");

  // Reset status comes from the straps and the link
  chk_reset_status: assert property (
    ($past(sys_rst) && !sys_rst) |->
      p2_duplex_now == $past(linkHalf))
    else $error("duplex default not derived");

  // A reload also reaches the backpressure output
  chk_reload_output: assert property (
    (strapReload && clkEn) |=>
      p2_backpressure_en == $past(p2_backpressure_strap))
    else $error("reload missed backpressure output");

  // A reload seeds both pause enables from one strap
  chk_reload_pair: assert property (
    (strapReload && clkEn) |=>
      cfg_q.rxEn == cfg_q.txEn)
    else $error("pause enables differ after reload");

  // Frozen enable also holds the status outputs
  chk_frozen_status: assert property (
    !clkEn |=>
      $stable(p2_rx_pause_now) && $stable(p2_tx_pause_now))
    else $error("status moved while frozen");

endmodule

// ---- test/p2fc_test.sv ----
`timescale 1ns/1ps
`include "p2fc_params.svh"
module p2fc_test import p2fc_pkg::*;;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1; // Dropped once to freeze
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic bpStrap = 1'b0;
  logic peStrap = 1'b0;
  logic manStrap = 1'b0;
  logic strapReload = 1'b0;
  logic anEnable = 1'b0;
  logic linkHalf = 1'b0;
  logic anRxPause = 1'b0;
  logic anTxPause = 1'b0;
  logic pready, pslverr, bpO, dupO, rxO, txO;
  logic [31:0] prdata;
  // Model state and bookkeeping
  int mBp, mRx, mTx, mMan;
  int errors = 0;
  int checkCount = 0;
  logic [31:0] seed = 32'h762b0a1f;

  // Clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  p2fc_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .p2_backpressure_strap(bpStrap),
    .p2_pause_enable_strap(peStrap), .p2_manual_select_strap(manStrap),
    .strapReload(strapReload), .anEnable(anEnable), .linkHalf(linkHalf),
    .anRxPause(anRxPause), .anTxPause(anTxPause), .p2_backpressure_en(bpO),
    .p2_duplex_now(dupO), .p2_rx_pause_now(rxO), .p2_tx_pause_now(txO));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Xorshift source
  function logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected register word from the model
  function logic [31:0] expWord();
    logic r, t;
    r = 1'b0;
    t = 1'b0;
    if (!linkHalf) begin
      if (mMan != 0 || !anEnable) begin
        r = mRx[0];
        t = mTx[0];
      end else begin
        r = anRxPause;
        t = anTxPause;
      end
    end
    return {25'h000_0000, mBp[0], linkHalf, r, t, mRx[0], mTx[0], mMan[0]};
  endfunction

  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  // One APB transfer
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    chk("wait", 32'h1, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read back the word and the live outputs
  task checkReg(input string tn);
    logic [31:0] rd, w;
    logic e;
    apb(1'b0, `P2FC_REG_OFFSET, 32'h0, rd, e);
    w = expWord();
    chk("word", w, rd);
    chk("slverr", 32'h0, {31'h0, e});
    chk("ports", {28'h0, w[6:3]}, {28'h0, bpO, dupO, rxO, txO});
    $display("test %s done", tn);
  endtask

  // Report and stop
  task finish_test;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r, d, rd;
    logic e;
    r = xrand();
    @(posedge clk_sys);
    bpStrap <= r[0];
    peStrap <= r[1];
    manStrap <= r[2];
    anEnable <= r[3];
    linkHalf <= r[4];
    anRxPause <= r[5];
    anTxPause <= r[6];
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    mBp = r[0];
    mRx = r[1];
    mTx = r[1];
    mMan = r[2];
    checkReg("reset");
    // Every mix of autoneg, duplex and select
    for (int i = 0; i < 16; i++) begin
      r = xrand();
      @(posedge clk_sys);
      anEnable <= i[0];
      linkHalf <= i[1];
      anRxPause <= r[8];
      anTxPause <= r[9];
      d = r;
      d[0] = i[2];
      apb(1'b1, `P2FC_REG_OFFSET, d, rd, e);
      chk("wr_ok", 32'h0, {31'h0, e});
      mBp = d[6];
      mRx = d[2];
      mTx = d[1];
      mMan = d[0];
      checkReg("mode");
    end
    // Neighbour addresses are not this register
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, i[0] ? 12'h1a8 : 12'h1a0, xrand(), rd, e);
      chk("wr_err", 32'h1, {31'h0, e});
      apb(1'b0, i[0] ? 12'h1a8 : 12'h1a0, 32'h0, rd, e);
      chk("rd_err", 32'h1, {31'h0, e});
      chk("rd_data", 32'h0, rd);
    end
    checkReg("unmapped");
    // Loader rewrites the straps
    r = xrand();
    @(posedge clk_sys);
    bpStrap <= ~mBp[0];
    peStrap <= r[1];
    manStrap <= ~mMan[0];
    strapReload <= 1'b1;
    @(posedge clk_sys);
    strapReload <= 1'b0;
    mBp = !mBp;
    mRx = r[1];
    mTx = r[1];
    mMan = !mMan;
    checkReg("reload");
    // Frozen enable ignores the loader; reset still acts
    @(posedge clk_sys);
    clkEn <= 1'b0;
    bpStrap <= ~mBp[0];
    peStrap <= r[3];
    manStrap <= r[4];
    strapReload <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("frozen", {31'h0, mBp[0]}, {31'h0, bpO});
    strapReload <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    clkEn <= 1'b1;
    mBp = !mBp;
    mRx = r[3];
    mTx = r[3];
    mMan = r[4];
    checkReg("freeze");
    finish_test;
  end

  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    errors++;
    finish_test;
  end
endmodule
